// [src/acac_top.sv]
// command decoder, correction registers and calibration engine
//
// How it works
// RULE1: output equals input minus offset, times gain
// RULE2: offset is signed, aligned to top bits
// RULE3: zero offset changes nothing; reset holds zero
// RULE4: gain unsigned fraction, unity code, reset unity
// RULE5: low, middle, high byte registers per word
// RULE6: host writes and calibration both load corrections
// RULE7: sinc-only path bypasses all correction
// RULE8: host recalibrates after amplifier gain change
// RULE9: restart, 64 periods, calibrate, 16 periods; calibration here does not restart and takes the next 16 valid readings
// RULE10: host holds sync input high throughout
// RULE11: zero calibration stores average of 16 readings
// RULE12: zero calibration readings skip gain scaling
// RULE13: span calibration makes average hit full scale
// RULE14: host leaves 24 clocks between bytes
// RULE15: host halts continuous read before register access
// RULE16: halt opcode stops automatic result output; here it only clears O_CONT_READ and O_DATA_VALID keeps pulsing
// RULE17: control opcodes ignore bit zero
// RULE18: exact codes for continuous, halt, single read
// RULE19: exact codes for zero and span calibration
// RULE20: register opcodes carry five-bit start address
// RULE21: second byte gives count minus one
// RULE22: all other opcodes are single byte
// RULE23: filter select value one means sinc only
// RULE24: register write restarts, 63 readings blanked
// RULE25: corrected result saturates instead of wrapping
`timescale 1ns/100ps
module acac_top
    import acac_pkg::*;
(
    // clocks and reset
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_LINK_CLK,
    input  wire logic        I_RESET_N,
    // command link, link clock domain
    input  wire logic [7:0]  I_LINK_BYTE,
    input  wire logic        I_LINK_BYTE_STB,
    output logic      [7:0]  O_LINK_RD_BYTE,
    output logic             O_LINK_RD_STB,
    // filter result input
    input  wire logic [31:0] I_FILT_DATA,
    input  wire logic        I_FILT_VALID,
    input  wire logic [1:0]  I_FILTER_PATH_SELECT,
    // corrected result output
    output logic      [31:0] O_DATA,
    output logic             O_DATA_VALID,
    // mode and status
    output logic             O_CONT_READ,
    output logic             O_STANDBY,
    output logic             O_CONV_RESTART,
    output logic             O_READ_ONCE,
    output logic             O_CAL_BUSY
);

    ////////////////////////////////////////////////////////////////////////////
    // link domain: byte capture and read-back presentation

    logic [7:0]      link_byte;
    logic            link_tog;
    logic [7:0]      rd_byte;
    logic            rd_tog;
    logic            rd_tog_s;
    logic            rd_tog_q;

    // byte is held stable until the next one, many clocks later
    always_ff @(posedge I_LINK_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            link_byte <= 8'h00;
            link_tog  <= 1'b0;
        end else if (I_LINK_BYTE_STB) begin
            link_byte <= I_LINK_BYTE;
            link_tog  <= ~link_tog;
        end
    end

    acac_sync #(.WIDTH(1)) u_rd_sync (
        .i_clk     (I_LINK_CLK),
        .i_reset_n (I_RESET_N),
        .i_async   (rd_tog),
        .o_sync    (rd_tog_s)
    );

    // rd_byte is steady long before its toggle arrives here
    always_ff @(posedge I_LINK_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rd_tog_q       <= 1'b0;
            O_LINK_RD_BYTE <= 8'h00;
            O_LINK_RD_STB  <= 1'b0;
        end else begin
            rd_tog_q      <= rd_tog_s;
            O_LINK_RD_STB <= rd_tog_s ^ rd_tog_q;
            if (rd_tog_s ^ rd_tog_q) begin
                O_LINK_RD_BYTE <= rd_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system domain: byte arrival and opcode decode

    logic            byte_tog_s;
    logic            byte_tog_q;
    acac_cmd_state_t state;
    logic            is_store;
    logic [4:0]      addr;
    logic [4:0]      remain;
    logic [7:0]      corr [CORR_REGS];
    logic            zcal_on;
    logic            scal_on;
    logic            div_busy;
    logic [5:0]      blank;

    acac_sync #(.WIDTH(1)) u_byte_sync (
        .i_clk     (I_CLK_SYS),
        .i_reset_n (I_RESET_N),
        .i_async   (link_tog),
        .o_sync    (byte_tog_s)
    );

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            byte_tog_q <= 1'b0;
        end else begin
            byte_tog_q <= byte_tog_s;
        end
    end

    // RULE14: byte gap keeps link_byte stable here
    wire       byte_evt    = byte_tog_s ^ byte_tog_q;
    wire [7:0] cmd_byte    = link_byte;
    wire       idle_evt    = byte_evt && (state == ST_IDLE);
    // RULE17: bit zero ignored for control opcodes
    wire       dec_wake    = cmd_byte[7:1] == OP_WAKE_HI7;
    wire       dec_standby = cmd_byte[7:1] == OP_STANDBY_HI7;
    wire       dec_restart = cmd_byte[7:1] == OP_RESTART_HI7;
    wire       dec_reset   = cmd_byte[7:1] == OP_RESET_HI7;
    // RULE18: exact read-mode codes
    wire       dec_cont    = cmd_byte == OP_CONT_READ;
    wire       dec_halt    = cmd_byte == OP_HALT_READ;
    wire       dec_once    = cmd_byte == OP_READ_ONCE;
    // RULE19: exact calibration codes
    wire       dec_zcal    = cmd_byte == OP_ZERO_CAL;
    wire       dec_scal    = cmd_byte == OP_SPAN_CAL;
    // RULE20: base code plus five-bit address
    wire       dec_fetch   = cmd_byte[7:5] == OP_FETCH_BASE;
    wire       dec_store   = cmd_byte[7:5] == OP_STORE_BASE;
    wire       reset_evt   = idle_evt && dec_reset;
    wire       cal_idle    = !(zcal_on || scal_on || div_busy);

    ////////////////////////////////////////////////////////////////////////////
    // register access sequencer

    // RULE21: count byte, then one data byte per register
    wire       count_evt  = byte_evt && (state == ST_COUNT);
    wire       store_evt  = byte_evt && (state == ST_STORE);
    wire       store_done = store_evt && (remain == 5'd0);
    wire       send_evt   = (count_evt && !is_store) ||
                            (byte_evt && (state == ST_FETCH) && (remain != 5'd0));
    wire [4:0] look_addr  = (state == ST_COUNT) ? addr : addr + 5'd1;
    wire       look_map   = (look_addr >= ADDR_OFS_LOW) && (look_addr <= ADDR_GAIN_HIGH);
    wire [4:0] look_off   = look_addr - ADDR_OFS_LOW;
    wire [7:0] look_val   = look_map ? corr[look_off[2:0]] : 8'h00;
    wire       addr_map   = (addr >= ADDR_OFS_LOW) && (addr <= ADDR_GAIN_HIGH);
    wire [4:0] addr_off   = addr - ADDR_OFS_LOW;
    wire       host_wr    = store_evt && addr_map;

    // RULE22: only register opcodes leave the idle state
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state    <= ST_IDLE;
            is_store <= 1'b0;
            addr     <= 5'd0;
            remain   <= 5'd0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (idle_evt && (dec_fetch || dec_store)) begin
                        state    <= ST_COUNT;
                        is_store <= dec_store;
                        addr     <= cmd_byte[4:0];
                    end
                end
                ST_COUNT: begin
                    if (byte_evt) begin
                        remain <= cmd_byte[4:0];
                        state  <= is_store ? ST_STORE : ST_FETCH;
                    end
                end
                ST_STORE, ST_FETCH: begin
                    if (byte_evt && (remain == 5'd0)) begin
                        state <= ST_IDLE;
                    end else if (byte_evt) begin
                        addr   <= addr + 5'd1;
                        remain <= remain - 5'd1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read-back byte goes out by toggle, one per requested register
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rd_byte <= 8'h00;
            rd_tog  <= 1'b0;
        end else if (send_evt) begin
            rd_byte <= look_val;
            rd_tog  <= ~rd_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction registers

    logic [23:0] zcal_val;
    logic        zcal_wr;
    logic [23:0] gain_val;
    logic        gain_wr;

    // RULE5: byte 0 low, byte 1 middle, byte 2 high
    wire [23:0] ofs_word   = {corr[2], corr[1], corr[0]};
    wire [23:0] gain_word  = {corr[5], corr[4], corr[3]};
    wire [47:0] reset_word = {GAIN_UNITY, OFS_RESET};

    // RULE6: reset command first, then calibration, then host
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            // RULE3: offset zero and RULE4: gain unity at reset
            for (int i = 0; i < CORR_REGS / 2; i++) begin
                corr[i]   <= OFS_RESET[8*i +: 8];
                corr[i+3] <= GAIN_UNITY[8*i +: 8];
            end
        end else if (reset_evt) begin
            for (int i = 0; i < CORR_REGS; i++) begin
                corr[i] <= reset_word[8*i +: 8];
            end
        end else begin
            if (host_wr) begin
                corr[addr_off[2:0]] <= cmd_byte;
            end
            if (zcal_wr) begin
                {corr[2], corr[1], corr[0]} <= zcal_val;
            end
            if (gain_wr) begin
                {corr[5], corr[4], corr[3]} <= gain_val;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // modes, restart and reading blank

    // RULE24: a completed write restarts conversion
    wire restart_evt = (idle_evt && (dec_restart || dec_reset)) || store_done;

    // RULE16: halt clears O_CONT_READ; O_DATA_VALID is not gated by it
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CONT_READ    <= 1'b1;
            O_STANDBY      <= 1'b0;
            O_CONV_RESTART <= 1'b0;
            O_READ_ONCE    <= 1'b0;
        end else begin
            O_CONV_RESTART <= restart_evt;
            O_READ_ONCE    <= idle_evt && dec_once;
            if (idle_evt && (dec_cont || dec_reset)) begin
                O_CONT_READ <= 1'b1;
            end else if (idle_evt && dec_halt) begin
                O_CONT_READ <= 1'b0;
            end
            if (idle_evt && (dec_wake || dec_reset)) begin
                O_STANDBY <= 1'b0;
            end else if (idle_evt && dec_standby) begin
                O_STANDBY <= 1'b1;
            end
        end
    end

    // RULE24: 63 readings discarded, 64th is first valid
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            blank <= RESTART_BLANK;
        end else if (restart_evt) begin
            blank <= RESTART_BLANK;
        end else if (I_FILT_VALID && (blank != 6'd0)) begin
            blank <= blank - 6'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // correction arithmetic

    logic signed [57:0] prod;

    // RULE23: select value one is the sinc-only path
    wire        sinc_only = I_FILTER_PATH_SELECT == FILT_SINC_ONLY;
    // RULE2: signed offset aligned above eight zero bits
    wire [32:0] diff      = {I_FILT_DATA[31], I_FILT_DATA} - {ofs_word[23], ofs_word, OFS_PAD};
    // RULE1: subtract, then scale by gain over unity
    assign prod           = $signed(diff) * $signed({1'b0, gain_word});
    wire        prod_ovf  = (prod[57:53] != {5{prod[53]}});
    // RULE25: clamp to full-scale codes on overflow
    wire [31:0] sat_gain  = prod_ovf ? (prod[57] ? SAT_NEG : SAT_POS)
                                     : prod[GAIN_FRAC_BITS +: 32];
    wire [31:0] diff_sat  = (diff[32] != diff[31]) ? (diff[32] ? SAT_NEG : SAT_POS)
                                                   : diff[31:0];
    // RULE7: sinc only passes raw; RULE12: zero cal skips gain
    wire [31:0] out_sel   = sinc_only ? I_FILT_DATA : (zcal_on ? diff_sat : sat_gain);

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_DATA       <= 32'h0000_0000;
            O_DATA_VALID <= 1'b0;
        end else begin
            O_DATA_VALID <= I_FILT_VALID && (blank == 6'd0);
            if (I_FILT_VALID) begin
                O_DATA <= out_sel;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // calibration: 16-reading average and gain division

    logic [3:0]  cal_cnt;
    logic [35:0] acc;
    logic [31:0] den;
    logic        div_sat;
    logic [32:0] rem;
    logic [24:0] num_sh;
    logic [24:0] quot;
    logic [4:0]  div_cnt;

    wire [53:0] num       = {FULL_SCALE, 22'h00_0000};
    wire        cal_take  = (zcal_on || scal_on) && I_FILT_VALID && (blank == 6'd0);
    wire        cal_last  = cal_take && (cal_cnt == CAL_LAST);
    // RULE11: zero cal averages raw readings
    wire [35:0] cal_smp   = zcal_on ? {{4{I_FILT_DATA[31]}}, I_FILT_DATA}
                                    : {{3{diff[32]}}, diff};
    wire [35:0] next_sum  = acc + cal_smp;
    wire [31:0] next_den  = next_sum[35:4];
    wire        den_bad   = next_den[31] || (next_den <= {3'b000, num[53:25]});
    wire [32:0] rem_sh    = {rem[31:0], num_sh[24]};
    wire        rem_ge    = rem_sh >= {1'b0, den};

    // RULE9: calibrate over the next 16 valid readings
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            zcal_on <= 1'b0;
            scal_on <= 1'b0;
            cal_cnt <= 4'd0;
            acc     <= 36'h0_0000_0000;
        end else if (reset_evt || cal_last) begin
            zcal_on <= 1'b0;
            scal_on <= 1'b0;
        end else if (idle_evt && cal_idle && (dec_zcal || dec_scal)) begin
            zcal_on <= dec_zcal;
            scal_on <= dec_scal;
            cal_cnt <= 4'd0;
            acc     <= 36'h0_0000_0000;
        end else if (cal_take) begin
            cal_cnt <= cal_cnt + 4'd1;
            acc     <= next_sum;
        end
    end

    // RULE13: gain = unity times full scale over average
    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            div_busy <= 1'b0;
            div_sat  <= 1'b0;
            div_cnt  <= 5'd0;
            den      <= 32'h0000_0000;
            rem      <= 33'h0_0000_0000;
            num_sh   <= 25'h000_0000;
            quot     <= 25'h000_0000;
        end else if (reset_evt) begin
            div_busy <= 1'b0;
        end else if (cal_last && scal_on) begin
            div_busy <= 1'b1;
            div_sat  <= den_bad;
            div_cnt  <= DIV_STEPS;
            den      <= next_den;
            rem      <= {4'h0, num[53:25]};
            num_sh   <= num[24:0];
        end else if (div_busy && (div_cnt != 5'd0)) begin
            div_cnt <= div_cnt - 5'd1;
            rem     <= rem_ge ? rem_sh - {1'b0, den} : rem_sh;
            num_sh  <= {num_sh[23:0], 1'b0};
            quot    <= {quot[23:0], rem_ge};
        end else if (div_busy) begin
            div_busy <= 1'b0;
        end
    end

    // RULE11: offset takes the top 24 bits of the average
    assign zcal_wr  = cal_last && zcal_on;
    assign zcal_val = next_sum[35:12];
    // RULE25: unreachable quotients clamp to the largest gain
    assign gain_wr  = div_busy && (div_cnt == 5'd0);
    assign gain_val = (div_sat || quot[24]) ? GAIN_MAX : quot[23:0];

    always_ff @(posedge I_CLK_SYS or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_CAL_BUSY <= 1'b0;
        end else begin
            O_CAL_BUSY <= zcal_on || scal_on || div_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_unity_pass;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_FILT_VALID && !sinc_only && !zcal_on && blank == 6'd0 &&
        ofs_word == OFS_RESET && gain_word == GAIN_UNITY
        |=> O_DATA_VALID && O_DATA == $past(I_FILT_DATA);
    endproperty
    a_unity_pass: assert property (p_unity_pass) else $error("unity path altered data"); // RULE1

    property p_sinc_bypass;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_FILT_VALID && sinc_only |=> O_DATA == $past(I_FILT_DATA);
    endproperty
    a_sinc_bypass: assert property (p_sinc_bypass) else $error("sinc path corrected"); // RULE7

    property p_zcal_nogain;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        I_FILT_VALID && zcal_on && !sinc_only |=> O_DATA == $past(diff_sat);
    endproperty
    a_zcal_nogain: assert property (p_zcal_nogain) else $error("gain during zero cal"); // RULE12

    property p_zcal_store;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        cal_last && zcal_on && !reset_evt |=> ofs_word == $past(next_sum[35:12]) && !zcal_on;
    endproperty
    a_zcal_store: assert property (p_zcal_store) else $error("offset average lost"); // RULE11

    property p_span_time;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        cal_last && scal_on && !reset_evt |=> div_busy [*8] ##19 !div_busy;
    endproperty
    a_span_time: assert property (p_span_time) else $error("span division timing"); // RULE13

    property p_store_restart;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        store_done |=> O_CONV_RESTART && blank == RESTART_BLANK && state == ST_IDLE;
    endproperty
    a_store_restart: assert property (p_store_restart) else $error("no restart"); // RULE24

    property p_low_byte;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        host_wr && addr == ADDR_OFS_LOW && !cal_last |=> ofs_word[7:0] == $past(cmd_byte);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte misplaced"); // RULE5

    property p_halt;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        idle_evt && dec_halt |=> !O_CONT_READ;
    endproperty
    a_halt: assert property (p_halt) else $error("halt ignored"); // RULE16

    property p_standby_lsb;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        idle_evt && cmd_byte[7:1] == OP_STANDBY_HI7 |=> O_STANDBY;
    endproperty
    a_standby_lsb: assert property (p_standby_lsb) else $error("standby missed"); // RULE17

    property p_single_byte;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        idle_evt && !dec_fetch && !dec_store |=> state == ST_IDLE;
    endproperty
    a_single_byte: assert property (p_single_byte) else $error("extra byte expected"); // RULE22

    property p_fetch_send;
        @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
        count_evt && !is_store |=> rd_tog != $past(rd_tog) && state == ST_FETCH;
    endproperty
    a_fetch_send: assert property (p_fetch_send) else $error("fetch not answered"); // RULE21

    c_zcal: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) zcal_wr);
    c_span: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) gain_wr);
    c_store: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) store_done);
    c_fetch: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESET_N) send_evt);

endmodule

// [include/acac_pkg.sv]
// constants and types for the adc command decoder and calibration engine
package acac_pkg;

    // single-byte control opcodes, matched on the upper seven bits
    localparam logic [6:0] OP_WAKE_HI7    = 7'h00;
    localparam logic [6:0] OP_STANDBY_HI7 = 7'h01;
    localparam logic [6:0] OP_RESTART_HI7 = 7'h02;
    localparam logic [6:0] OP_RESET_HI7   = 7'h03;

    // exact-value opcodes
    localparam logic [7:0] OP_CONT_READ = 8'h10;
    localparam logic [7:0] OP_HALT_READ = 8'h11;
    localparam logic [7:0] OP_READ_ONCE = 8'h12;
    localparam logic [7:0] OP_ZERO_CAL  = 8'h60;
    localparam logic [7:0] OP_SPAN_CAL  = 8'h61;

    // register access opcodes: base in bits 7:5, address in bits 4:0
    localparam logic [2:0] OP_FETCH_BASE = 3'h1;
    localparam logic [2:0] OP_STORE_BASE = 3'h2;

    // correction register addresses
    localparam logic [4:0] ADDR_OFS_LOW   = 5'h05;
    localparam logic [4:0] ADDR_GAIN_HIGH = 5'h0A;
    localparam int         CORR_REGS      = 6;

    // reset values and scaling
    localparam logic [23:0] OFS_RESET      = 24'h00_0000;
    localparam logic [23:0] GAIN_UNITY     = 24'h40_0000;
    localparam logic [23:0] GAIN_MAX       = 24'hFF_FFFF;
    localparam int          GAIN_FRAC_BITS = 22;
    localparam logic [7:0]  OFS_PAD        = 8'h00;
    localparam logic [1:0]  FILT_SINC_ONLY = 2'h1;
    localparam logic [31:0] SAT_POS        = 32'h7FFF_FFFF;
    localparam logic [31:0] SAT_NEG        = 32'h8000_0000;
    localparam logic [31:0] FULL_SCALE     = 32'h7FFF_FFFF;

    // timing counts in readings or clock cycles
    localparam logic [5:0] RESTART_BLANK = 6'd63;
    localparam logic [3:0] CAL_LAST      = 4'd15;
    localparam logic [4:0] DIV_STEPS     = 5'd25;

    // command decoder states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COUNT,
        ST_STORE,
        ST_FETCH
    } acac_cmd_state_t;

endpackage

// [src/acac_sync.sv]
// two-flop level synchroniser
`timescale 1ns/100ps
module acac_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // level from the other domain and its safe copy
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta   <= '0;
            o_sync <= '0;
        end else begin
            meta   <= i_async;
            o_sync <= meta;
        end
    end

endmodule

// [tb/acac_host.sv]
// host model sending command bytes on the link
`timescale 1ns/100ps
module acac_host (
    // link side
    input  wire logic       i_clk,
    output logic      [7:0] o_byte,
    output logic            o_stb
);
    // strobe idles low; byte lane starts at zero, then holds the inverse of the last byte
    initial begin
        o_byte = 8'h00;
        o_stb  = 1'b0;
    end
    // byte spacing
    // 80 link cycles give margin over 24 system clocks
    task automatic send(input logic [7:0] b);
        @(posedge i_clk);
        o_byte <= b;
        o_stb  <= 1'b1;
        @(posedge i_clk);
        o_stb  <= 1'b0;
        o_byte <= ~b;
        repeat (80) @(posedge i_clk);
    endtask
endmodule

// [tb/acac_top_tb.sv]
// self-checking bench for the correction and command block
`timescale 1ns/100ps
module acac_top_tb;
    import acac_pkg::*;
    logic        clk, lclk, rst_n, fv, ls, rs, dv, cont, zc, sb, cr, ro, cb;
    logic [31:0] fd, dout, lf;
    logic [7:0]  lb, rb, rq[$];
    logic [7:0]  wb [6] = '{8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h80};
    logic [1:0]  fsel;
    int          fail_count, checks, blank, n_cr, n_ro;
    longint      ofs, gain;
    acac_top uut (.I_CLK_SYS(clk), .I_LINK_CLK(lclk), .I_RESET_N(rst_n),
        .I_LINK_BYTE(lb), .I_LINK_BYTE_STB(ls), .O_LINK_RD_BYTE(rb), .O_LINK_RD_STB(rs),
        .I_FILT_DATA(fd), .I_FILT_VALID(fv), .I_FILTER_PATH_SELECT(fsel),
        .O_DATA(dout), .O_DATA_VALID(dv), .O_CONT_READ(cont), .O_STANDBY(sb),
        .O_CONV_RESTART(cr), .O_READ_ONCE(ro), .O_CAL_BUSY(cb));
    acac_host host (.i_clk(lclk), .o_byte(lb), .o_stb(ls));
    // clocks, link phase unrelated
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #7 forever #16 lclk = ~lclk;
    end
    // collect read-back bytes
    always @(posedge lclk) if (rs === 1'b1) rq.push_back(rb);
    // count one-cycle pulses; seen one edge after launch
    always @(posedge clk) begin
        if (cr === 1'b1) n_cr++;
        if (ro === 1'b1) n_ro++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    function automatic logic [31:0] next_lf(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // reference result: offset on top bits, gain over unity, clipped
    function automatic logic [31:0] model(input logic [31:0] x);
        longint d;
        if (fsel == FILT_SINC_ONLY) return x;
        d = longint'($signed(x)) - (ofs <<< 8);
        if (!zc) d = (d * gain) >>> GAIN_FRAC_BITS;
        if (d > longint'($signed(SAT_POS))) return SAT_POS;
        if (d < longint'($signed(SAT_NEG))) return SAT_NEG;
        return d[31:0];
    endfunction
    // one reading, result one cycle later
    task automatic rd(input logic [31:0] x);
        @(posedge clk);
        fd <= x;
        fv <= 1'b1;
        @(posedge clk);
        fv <= 1'b0;
        @(negedge clk);
        check(dv, blank == 0);
        if (dv === 1'b1) check(dout, model(x));
        if (blank > 0) blank--;
    endtask
    task automatic run(input int n);
        repeat (n) begin
            lf = next_lf(lf);
            rd(lf);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        fv = 1'b0;
        fd = 32'h0000_0000;
        fsel = 2'h2;
        zc = 1'b0;
        lf = 32'h0000_0024;
        blank = 63;
        ofs = OFS_RESET;
        gain = GAIN_UNITY;
        fail_count = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        check(cont, 1'b1);
        run(70);
        host.send(OP_HALT_READ);
        check(cont, 1'b0);
        host.send({OP_STORE_BASE, ADDR_OFS_LOW});
        host.send(8'h05);
        foreach (wb[i]) host.send(wb[i]);
        ofs = longint'($signed({wb[2], wb[1], wb[0]}));
        gain = {wb[5], wb[4], wb[3]};
        blank = 63;
        host.send({OP_FETCH_BASE, ADDR_OFS_LOW});
        host.send(8'h05);
        repeat (6) host.send(8'h00);
        check(rq.size(), 6);
        foreach (wb[i]) check(rq[i], wb[i]);
        run(80);
        @(posedge clk) fsel <= FILT_SINC_ONLY;
        run(8);
        @(posedge clk) fsel <= 2'h2;
        host.send({OP_STANDBY_HI7, 1'b1});
        check(sb, 1'b1);
        host.send({OP_WAKE_HI7, 1'b1});
        check(sb, 1'b0);
        host.send(OP_READ_ONCE);
        check(n_ro, 1);
        // amplifier gain and sync level never change here
        host.send({OP_RESTART_HI7, 1'b0});
        host.send(OP_CONT_READ);
        check(cont, 1'b1);
        check(n_cr, 2);
        blank = 63;
        run(64);
        host.send(OP_HALT_READ);
        host.send(OP_ZERO_CAL);
        host.send(OP_CONT_READ);
        check(cb, 1'b1);
        zc = 1'b1;
        lf = 32'h0012_3400;
        repeat (16) rd(lf);
        zc = 1'b0;
        ofs = longint'($signed(lf[31:8]));
        run(20);
        check(cb, 1'b0);
        host.send(OP_SPAN_CAL);
        lf = 32'h4012_3400;
        repeat (16) rd(lf);
        repeat (30) @(posedge clk);
        check(cb, 1'b0);
        // span target: full scale over the corrected average
        gain = longint'($signed(lf)) - (ofs <<< 8);
        gain = (longint'(FULL_SCALE) <<< GAIN_FRAC_BITS) / gain;
        run(20);
        host.send({OP_RESET_HI7, 1'b1});
        ofs = OFS_RESET;
        gain = GAIN_UNITY;
        blank = 63;
        check(n_cr, 3);
        run(70);
        end_of_test();
    end
endmodule
